// >>> hdl/bscan_pkg.sv
// Constants, opcodes and controller states of the boundary-scan logic
package bscan_pkg;

  // Instruction register
  localparam int IR_W = 6;
  localparam logic [IR_W-1:0] OP_EXTEST = 6'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE = 6'h01;
  localparam logic [IR_W-1:0] OP_IDCODE = 6'h02;
  localparam logic [IR_W-1:0] OP_HIGHZ = 6'h03;
  localparam logic [IR_W-1:0] OP_CAPTURE_IR_PATTERN = 6'h2D;
  localparam logic [IR_W-1:0] OP_CLAMP = 6'h3E;
  localparam logic [IR_W-1:0] OP_BYPASS = 6'h3F;

  // Identification register layout
  localparam int ID_W = 32;
  localparam int ID_MANUF_W = 11;
  localparam int ID_PART_W = 16;
  localparam int ID_VER_W = 4;
  localparam logic ID_MARKER = 1'h1;

  // Boundary chain make-up
  localparam int N_IN = 4;
  localparam int N_OUT = 2;
  localparam int N_BIDIR = 2;
  localparam int OUT_BASE = N_IN;
  localparam int OE_BASE = N_IN + N_OUT;
  localparam int BD_BASE = OE_BASE + N_BIDIR;
  localparam int N_CELLS = BD_BASE + N_BIDIR;

  // Test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4,
    TAP_EX1_DR = 4'h5,
    TAP_PA_DR = 4'h6,
    TAP_EX2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA,
    TAP_SH_IR = 4'hB,
    TAP_EX1_IR = 4'hC,
    TAP_PA_IR = 4'hD,
    TAP_EX2_IR = 4'hE,
    TAP_UPD_IR = 4'hF
  } tap_state_e;

  // Serial path between data in and data out during data scans
  typedef enum logic [1:0] {
    PATH_BYP = 2'h0,
    PATH_BSR = 2'h1,
    PATH_ID = 2'h2
  } path_e;

endpackage : bscan_pkg

// >>> hdl/bscan_cell.sv
// One boundary-scan cell: capture/shift stage plus update latch
`timescale 1ns/1ps
module bscan_cell (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_capture,
  input wire logic i_shift,
  input wire logic i_update,
  input wire logic i_cap_d,
  input wire logic i_si,
  output logic o_so,
  output logic o_upd
);

  typedef struct packed {
    logic sh;
    logic upd;
  } cell_s;

  cell_s c_r;
  cell_s c_nxt;

  // Capture or shift on the test clock rise, latch on its fall
  always_comb begin
    c_nxt = c_r;
    if (i_capture) begin
      c_nxt.sh = i_cap_d;
    end else if (i_shift) begin
      c_nxt.sh = i_si;
    end
    if (i_update) begin
      c_nxt.upd = c_r.sh;
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign o_so = c_r.sh;
  assign o_upd = c_r.upd;

endmodule : bscan_cell

// >>> hdl/boundary_scan_instruction_logic.sv
// Boundary-scan instruction register, data registers and pin control
//
// Summary of operation
// - Bypass, boundary, ID registers share serial path
// - External test and sample route boundary chain
// - External test drives latched values at once
// - Every cell latches on falling test clock
// - Input pin cells observe only, never drive
// - Bidirectional pin uses enable and capture cell
// - Enable high, no external test: capture core data
// - Enable low or external test: capture pad
// - Instruction shifts on rise, applies at update
// - Six-bit instruction selects register and path
// - Unselected boundary and ID registers stay quiet
// - Opcode 000010 selects identification register
// - Opcode 000011 tri-states all output cells
// - Capture-IR loads pattern 101101
// - Clamp drives pins from cells, path bypass
// - Opcode 111111 gives one-bit bypass path
// - External test applies shifted values at Update-DR
// - External test keeps latched values on outputs
// - Sample snapshots pins and allows preload
// - Data out driven only while shifting, falling edge
// - Bypass stage cleared in Capture-DR
// - Controller reset makes identification current
`timescale 1ns/1ps
module boundary_scan_instruction_logic #(
  parameter logic [bscan_pkg::ID_VER_W-1:0] ID_VERSION = 4'h1, // Arbitrary value
  parameter logic [bscan_pkg::ID_PART_W-1:0] ID_PART = 16'h1234, // Arbitrary value
  parameter logic [bscan_pkg::ID_MANUF_W-1:0] ID_MANUF = 11'h05A // Arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_b,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [bscan_pkg::N_IN-1:0] i_in_pin,
  input wire logic [bscan_pkg::N_OUT-1:0] i_core_out,
  output logic [bscan_pkg::N_OUT-1:0] o_out_pin,
  output logic [bscan_pkg::N_OUT-1:0] o_out_oe,
  input wire logic [bscan_pkg::N_BIDIR-1:0] i_core_bd_out,
  input wire logic [bscan_pkg::N_BIDIR-1:0] i_core_bd_oe,
  input wire logic [bscan_pkg::N_BIDIR-1:0] i_bd_pin,
  output logic [bscan_pkg::N_BIDIR-1:0] o_bd_pin,
  output logic [bscan_pkg::N_BIDIR-1:0] o_bd_oe
);

  localparam logic [bscan_pkg::ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MANUF,
                                                     bscan_pkg::ID_MARKER};

  typedef struct packed {
    logic tck_m;
    logic tck_q;
    logic tck_prev;
    logic tms_m;
    logic tms_q;
    logic tdi_m;
    logic tdi_q;
    logic trst_m;
    logic trst_q;
    logic [bscan_pkg::N_IN-1:0] in_m;
    logic [bscan_pkg::N_IN-1:0] in_q;
    logic [bscan_pkg::N_BIDIR-1:0] bd_m;
    logic [bscan_pkg::N_BIDIR-1:0] bd_q;
    bscan_pkg::tap_state_e tap;
    logic [bscan_pkg::IR_W-1:0] ir_shift;
    logic [bscan_pkg::IR_W-1:0] ir_cur;
    logic bypass;
    logic [bscan_pkg::ID_W-1:0] id_shift;
    logic tdo;
    logic tdo_oe;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Controller next state from mode select
  function automatic bscan_pkg::tap_state_e tap_next(input bscan_pkg::tap_state_e st,
                                                     input logic tms);
    case (st)
      bscan_pkg::TAP_RESET: tap_next = tms ? bscan_pkg::TAP_RESET : bscan_pkg::TAP_IDLE;
      bscan_pkg::TAP_IDLE: tap_next = tms ? bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
      bscan_pkg::TAP_SEL_DR: tap_next = tms ? bscan_pkg::TAP_SEL_IR : bscan_pkg::TAP_CAP_DR;
      bscan_pkg::TAP_CAP_DR: tap_next = tms ? bscan_pkg::TAP_EX1_DR : bscan_pkg::TAP_SH_DR;
      bscan_pkg::TAP_SH_DR: tap_next = tms ? bscan_pkg::TAP_EX1_DR : bscan_pkg::TAP_SH_DR;
      bscan_pkg::TAP_EX1_DR: tap_next = tms ? bscan_pkg::TAP_UPD_DR : bscan_pkg::TAP_PA_DR;
      bscan_pkg::TAP_PA_DR: tap_next = tms ? bscan_pkg::TAP_EX2_DR : bscan_pkg::TAP_PA_DR;
      bscan_pkg::TAP_EX2_DR: tap_next = tms ? bscan_pkg::TAP_UPD_DR : bscan_pkg::TAP_SH_DR;
      bscan_pkg::TAP_UPD_DR: tap_next = tms ? bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
      bscan_pkg::TAP_SEL_IR: tap_next = tms ? bscan_pkg::TAP_RESET : bscan_pkg::TAP_CAP_IR;
      bscan_pkg::TAP_CAP_IR: tap_next = tms ? bscan_pkg::TAP_EX1_IR : bscan_pkg::TAP_SH_IR;
      bscan_pkg::TAP_SH_IR: tap_next = tms ? bscan_pkg::TAP_EX1_IR : bscan_pkg::TAP_SH_IR;
      bscan_pkg::TAP_EX1_IR: tap_next = tms ? bscan_pkg::TAP_UPD_IR : bscan_pkg::TAP_PA_IR;
      bscan_pkg::TAP_PA_IR: tap_next = tms ? bscan_pkg::TAP_EX2_IR : bscan_pkg::TAP_PA_IR;
      bscan_pkg::TAP_EX2_IR: tap_next = tms ? bscan_pkg::TAP_UPD_IR : bscan_pkg::TAP_SH_IR;
      bscan_pkg::TAP_UPD_IR: tap_next = tms ? bscan_pkg::TAP_SEL_DR : bscan_pkg::TAP_IDLE;
      default: tap_next = bscan_pkg::TAP_RESET;
    endcase
  endfunction : tap_next

  // Data register chosen by an instruction
  function automatic bscan_pkg::path_e path_of(input logic [bscan_pkg::IR_W-1:0] ir);
    case (ir)
      bscan_pkg::OP_EXTEST: path_of = bscan_pkg::PATH_BSR;
      bscan_pkg::OP_SAMPLE: path_of = bscan_pkg::PATH_BSR;
      bscan_pkg::OP_IDCODE: path_of = bscan_pkg::PATH_ID;
      default: path_of = bscan_pkg::PATH_BYP;
    endcase
  endfunction : path_of

  // Instructions under which the cells own the pins
  function automatic logic cells_drive(input logic [bscan_pkg::IR_W-1:0] ir);
    cells_drive = (ir == bscan_pkg::OP_EXTEST) || (ir == bscan_pkg::OP_CLAMP);
  endfunction : cells_drive

  logic tck_rise;
  logic tck_fall;
  logic bsr_sel;
  logic extest;
  logic highz;
  logic test_drive;
  logic in_shift;
  logic [bscan_pkg::N_CELLS-1:0] cell_so;
  logic [bscan_pkg::N_CELLS-1:0] cell_si;
  logic [bscan_pkg::N_CELLS-1:0] cell_upd;
  logic [bscan_pkg::N_CELLS-1:0] cell_cap_d;
  logic cell_capture;
  logic cell_shift;
  logic cell_update;
  logic serial_out;

  // Test clock edges seen by the reference clock
  assign tck_rise = s_r.tck_q & ~s_r.tck_prev;
  assign tck_fall = ~s_r.tck_q & s_r.tck_prev;

  // Instruction decode
  assign bsr_sel = (path_of(s_r.ir_cur) == bscan_pkg::PATH_BSR);
  assign extest = (s_r.ir_cur == bscan_pkg::OP_EXTEST);
  assign highz = (s_r.ir_cur == bscan_pkg::OP_HIGHZ);
  assign test_drive = cells_drive(s_r.ir_cur);
  assign in_shift = (s_r.tap == bscan_pkg::TAP_SH_DR) || (s_r.tap == bscan_pkg::TAP_SH_IR);

  // Boundary chain strobes, quiet unless the chain is selected
  assign cell_capture = tck_rise && (s_r.tap == bscan_pkg::TAP_CAP_DR) && bsr_sel;
  assign cell_shift = tck_rise && (s_r.tap == bscan_pkg::TAP_SH_DR) && bsr_sel;
  assign cell_update = tck_fall && (s_r.tap == bscan_pkg::TAP_UPD_DR) && bsr_sel;

  // Capture sources per cell kind
  genvar gi;
  generate
    for (gi = 0; gi < bscan_pkg::N_IN; gi++) begin : g_in
      assign cell_cap_d[gi] = s_r.in_q[gi];
    end
    for (gi = 0; gi < bscan_pkg::N_OUT; gi++) begin : g_out
      assign cell_cap_d[bscan_pkg::OUT_BASE+gi] = i_core_out[gi];
      assign o_out_pin[gi] = test_drive ? cell_upd[bscan_pkg::OUT_BASE+gi] : i_core_out[gi];
      assign o_out_oe[gi] = ~highz;
    end
    for (gi = 0; gi < bscan_pkg::N_BIDIR; gi++) begin : g_bd
      assign cell_cap_d[bscan_pkg::OE_BASE+gi] = i_core_bd_oe[gi];
      assign cell_cap_d[bscan_pkg::BD_BASE+gi] =
        (cell_upd[bscan_pkg::OE_BASE+gi] && !extest) ? i_core_bd_out[gi]
                                                     : s_r.bd_q[gi];
      assign o_bd_pin[gi] = test_drive ? cell_upd[bscan_pkg::BD_BASE+gi] : i_core_bd_out[gi];
      assign o_bd_oe[gi] = highz ? 1'h0 :
                           (test_drive ? cell_upd[bscan_pkg::OE_BASE+gi] : i_core_bd_oe[gi]);
    end
    for (gi = 0; gi < bscan_pkg::N_CELLS; gi++) begin : g_chain
      assign cell_si[gi] = (gi == 0) ? s_r.tdi_q : cell_so[(gi == 0) ? 0 : gi-1];
      bscan_cell u_cell (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_capture(cell_capture),
        .i_shift(cell_shift),
        .i_update(cell_update),
        .i_cap_d(cell_cap_d[gi]),
        .i_si(cell_si[gi]),
        .o_so(cell_so[gi]),
        .o_upd(cell_upd[gi])
      );
    end
  endgenerate

  // Serial source for the next data-out bit
  always_comb begin
    if (s_r.tap == bscan_pkg::TAP_SH_IR) begin
      serial_out = s_r.ir_shift[0];
    end else begin
      case (path_of(s_r.ir_cur))
        bscan_pkg::PATH_BSR: serial_out = cell_so[bscan_pkg::N_CELLS-1];
        bscan_pkg::PATH_ID: serial_out = s_r.id_shift[0];
        default: serial_out = s_r.bypass;
      endcase
    end
  end

  // Next state of synchronisers, controller and registers
  always_comb begin
    s_nxt = s_r;
    s_nxt.tck_m = i_tck;
    s_nxt.tck_q = s_r.tck_m;
    s_nxt.tck_prev = s_r.tck_q;
    s_nxt.tms_m = i_tms;
    s_nxt.tms_q = s_r.tms_m;
    s_nxt.tdi_m = i_tdi;
    s_nxt.tdi_q = s_r.tdi_m;
    s_nxt.trst_m = i_trst_b;
    s_nxt.trst_q = s_r.trst_m;
    s_nxt.in_m = i_in_pin;
    s_nxt.in_q = s_r.in_m;
    s_nxt.bd_m = i_bd_pin;
    s_nxt.bd_q = s_r.bd_m;
    if (tck_rise) begin
      s_nxt.tap = tap_next(s_r.tap, s_r.tms_q);
      case (s_r.tap)
        bscan_pkg::TAP_CAP_IR: begin
          s_nxt.ir_shift = bscan_pkg::OP_CAPTURE_IR_PATTERN;
        end
        bscan_pkg::TAP_SH_IR: begin
          s_nxt.ir_shift = {s_r.tdi_q, s_r.ir_shift[bscan_pkg::IR_W-1:1]};
        end
        bscan_pkg::TAP_CAP_DR: begin
          s_nxt.bypass = 1'h0;
          if (path_of(s_r.ir_cur) == bscan_pkg::PATH_ID) begin
            s_nxt.id_shift = ID_VALUE;
          end
        end
        bscan_pkg::TAP_SH_DR: begin
          if (path_of(s_r.ir_cur) == bscan_pkg::PATH_BYP) begin
            s_nxt.bypass = s_r.tdi_q;
          end
          if (path_of(s_r.ir_cur) == bscan_pkg::PATH_ID) begin
            s_nxt.id_shift = {s_r.tdi_q, s_r.id_shift[bscan_pkg::ID_W-1:1]};
          end
        end
        default: begin
          s_nxt.bypass = s_r.bypass;
        end
      endcase
    end
    if (tck_fall) begin
      if (s_r.tap == bscan_pkg::TAP_UPD_IR) begin
        s_nxt.ir_cur = s_r.ir_shift;
      end
      s_nxt.tdo_oe = in_shift;
      if (in_shift) begin
        s_nxt.tdo = serial_out;
      end
    end
    if (s_r.tap == bscan_pkg::TAP_RESET) begin
      s_nxt.ir_cur = bscan_pkg::OP_IDCODE;
    end
    if (!s_r.trst_q) begin
      s_nxt.tap = bscan_pkg::TAP_RESET;
      s_nxt.tdo_oe = 1'h0;
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '0;
      s_r.tap <= bscan_pkg::TAP_RESET;
      s_r.ir_cur <= bscan_pkg::OP_IDCODE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_tdo = s_r.tdo;
  assign o_tdo_oe = s_r.tdo_oe;

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_capture_ir;
    tck_rise && s_r.tap == bscan_pkg::TAP_CAP_IR |=>
      s_r.ir_shift == bscan_pkg::OP_CAPTURE_IR_PATTERN;
  endproperty
  a_capture_ir: assert property (p_capture_ir)
    else $error("capture-IR did not load the fixed pattern");

  property p_ir_update;
    tck_fall && s_r.tap == bscan_pkg::TAP_UPD_IR |=> s_r.ir_cur == $past(s_r.ir_shift);
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("instruction not applied at update-IR");

  property p_ir_hold;
    s_r.tap != bscan_pkg::TAP_RESET && !(tck_fall && s_r.tap == bscan_pkg::TAP_UPD_IR)
      |=> $stable(s_r.ir_cur);
  endproperty
  a_ir_hold: assert property (p_ir_hold)
    else $error("instruction changed outside update-IR");

  property p_reset_id;
    s_r.tap == bscan_pkg::TAP_RESET |=> s_r.ir_cur == bscan_pkg::OP_IDCODE;
  endproperty
  a_reset_id: assert property (p_reset_id)
    else $error("identification not current after controller reset");

  property p_bypass_clear;
    tck_rise && s_r.tap == bscan_pkg::TAP_CAP_DR |=> !s_r.bypass;
  endproperty
  a_bypass_clear: assert property (p_bypass_clear)
    else $error("bypass stage not cleared in capture-DR");

  property p_tdo_enable;
    $rose(s_r.tdo_oe) |-> $past(tck_fall) && $past(in_shift);
  endproperty
  a_tdo_enable: assert property (p_tdo_enable)
    else $error("data out enabled outside a shift state");

  property p_tdo_edge;
    $changed(s_r.tdo) |-> $past(tck_fall);
  endproperty
  a_tdo_edge: assert property (p_tdo_edge)
    else $error("data out changed away from a falling test clock");

  property p_highz;
    highz |-> o_out_oe == '0 && o_bd_oe == '0;
  endproperty
  a_highz: assert property (p_highz)
    else $error("output driven while tri-state instruction current");

  property p_cell_update;
    cell_update |=> cell_upd == $past(cell_so);
  endproperty
  a_cell_update: assert property (p_cell_update)
    else $error("boundary latches missed update-DR");

  property p_quiet_chain;
    !bsr_sel ##1 !bsr_sel |-> $stable(cell_so) && $stable(cell_upd);
  endproperty
  a_quiet_chain: assert property (p_quiet_chain)
    else $error("boundary chain moved while not selected");

  property p_reserved_functional;
    path_of(s_r.ir_cur) == bscan_pkg::PATH_BYP && !test_drive && !highz |->
      o_out_pin == i_core_out && o_bd_pin == i_core_bd_out && o_bd_oe == i_core_bd_oe;
  endproperty
  a_reserved_functional: assert property (p_reserved_functional)
    else $error("pins not under functional control");

endmodule : boundary_scan_instruction_logic

// >>> dv/jtag_tester.sv
// Board-level scan controller model that drives the test pins
`timescale 1ns/1ps
module jtag_tester (
  input wire logic i_ref_clk,
  input wire logic i_tdo,
  input wire logic i_tdo_oe,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_b
);
  logic last_tdi;

  // Idle levels: clock parked low, reset released
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_b = 1'b1;
    last_tdi = 1'b1;
  end

  // Wait n reference edges, then step just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step

  // One 800 ns test clock period; data out taken after the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
    o_tms = tms;
    o_tdi = tdi;
    last_tdi = tdi;
    step(4);
    o_tck = 1'b1;
    step(2);
    // Undriven data out reads as the inverse of its last level
    tdo = i_tdo_oe ? i_tdo : ~i_tdo;
    oe = i_tdo_oe;
    step(2);
    o_tck = 1'b0;
  endtask : tick

  // Navigation period; data line toggles so a stale value never looks valid
  task automatic nav(input logic tms, output logic oe);
    logic t;
    tick(tms, ~last_tdi, t, oe);
  endtask : nav

  // Test reset pulse, with the clock standing still around it
  task automatic trst();
    o_trst_b = 1'b0;
    step(4);
    o_trst_b = 1'b1;
    step(5);
  endtask : trst
endmodule : jtag_tester

// >>> dv/boundary_scan_instruction_logic_tb.sv
// Self-checking bench for the boundary-scan instruction and data register logic
`timescale 1ns/1ps
module boundary_scan_instruction_logic_tb;
  localparam logic [3:0] VER = 4'h6; // Arbitrary value
  localparam logic [15:0] PART = 16'hC3A5; // Arbitrary value
  localparam logic [10:0] MANUF = 11'h2B1; // Arbitrary value
  logic i_ref_clk, i_rst_b, i_tck, i_tms, i_tdi, i_trst_b, o_tdo, o_tdo_oe, e;
  logic [3:0] i_in_pin;
  logic [1:0] i_core_out, o_out_pin, o_out_oe, i_core_bd_out, i_core_bd_oe;
  logic [1:0] i_bd_pin, o_bd_pin, o_bd_oe, ext_bd;
  logic [31:0] rng, r;
  logic [9:0] lat, pre;
  logic [5:0] ir;
  logic [5:0] ops[5];
  int fails, tests_run;

  // Pad level resolved from both drivers
  assign i_bd_pin = (o_bd_oe & o_bd_pin) | (~o_bd_oe & ext_bd);

  boundary_scan_instruction_logic #(.ID_VERSION(VER), .ID_PART(PART), .ID_MANUF(MANUF)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
    .i_trst_b(i_trst_b), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_in_pin(i_in_pin),
    .i_core_out(i_core_out), .o_out_pin(o_out_pin), .o_out_oe(o_out_oe),
    .i_core_bd_out(i_core_bd_out), .i_core_bd_oe(i_core_bd_oe), .i_bd_pin(i_bd_pin),
    .o_bd_pin(o_bd_pin), .o_bd_oe(o_bd_oe));

  jtag_tester i_tester (.i_ref_clk(i_ref_clk), .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe),
    .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .o_trst_b(i_trst_b));

  // Reference clock, 100 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  function automatic logic [9:0] rev(input logic [9:0] v);
    for (int i = 0; i < 10; i++) rev[i] = v[9 - i];
  endfunction : rev

  // Expected chain capture, cell-indexed; ext set under external test
  function automatic logic [9:0] cap(input logic ext);
    logic [1:0] oe = ext ? lat[7:6] : i_core_bd_oe;
    logic [1:0] dat = ext ? lat[9:8] : i_core_bd_out;
    logic [1:0] pad = (oe & dat) | (~oe & ext_bd);
    logic [1:0] sel = lat[7:6] & ~{2{ext}};
    logic [1:0] bd = (sel & i_core_bd_out) | (~sel & pad);
    return {bd, i_core_bd_oe, i_core_out, i_in_pin};
  endfunction : cap

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  // Shift n bits through IR or DR, starting and ending in Idle
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    i_tester.nav(1'b1, e);
    if (is_ir) i_tester.nav(1'b1, e);
    i_tester.nav(1'b0, e);
    i_tester.nav(1'b0, e);
    for (int i = 0; i < n; i++) begin
      i_tester.tick(i == n - 1, din[i], o, e);
      dout[i] = o;
      chk(e === 1'b1, "data out idle while shifting");
    end
    i_tester.nav(1'b1, e);
    i_tester.nav(1'b0, e);
    chk(e === 1'b0, "data out driven outside shift");
  endtask : scan

  task automatic load_ir(input logic [5:0] op);
    logic [31:0] d;
    scan(1'b1, 6, {26'h000_0000, op}, d);
    chk(d[5:0] === 6'h2D, "instruction capture pattern");
    ir = op;
  endtask : load_ir

  task automatic dr(input int n, input logic [31:0] din, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    scan(1'b0, n, din, d);
    chk(d === exp, msg);
  endtask : dr

  // Pins against the model for the current instruction
  task automatic pins(input string msg);
    logic [7:0] p = {o_out_pin, o_out_oe, o_bd_pin, o_bd_oe};
    if (ir == 6'h03) chk((o_out_oe | o_bd_oe) === 2'b00, msg);
    else if (ir == 6'h00 || ir == 6'h3E) chk(p === {lat[5:4], 2'b11, lat[9:8], lat[7:6]}, msg);
    else chk(p === {i_core_out, 2'b11, i_core_bd_out, i_core_bd_oe}, msg);
  endtask : pins

  // New random core and pad values, just after a reference edge
  task automatic stir();
    @(posedge i_ref_clk);
    #1;
    r = xs();
    {i_in_pin, i_core_out, i_core_bd_out, i_core_bd_oe, ext_bd} = r[11:0];
  endtask : stir

  task automatic id_check(input string msg);
    i_tester.nav(1'b0, e);
    ir = 6'h02;
    dr(32, xs(), {VER, PART, MANUF, 1'b1}, msg);
    pins(msg);
  endtask : id_check

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // Hang guard, over three and a half times the expected run
  initial begin
    #1_000_000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    {i_rst_b, i_in_pin, i_core_out, i_core_bd_out, i_core_bd_oe, ext_bd} = '0;
    rng = 32'h0000_0049;
    lat = '0;
    fails = 0;
    tests_run = 0;
    repeat (10) @(posedge i_ref_clk);
    #1;
    i_rst_b = 1'b1;
    i_tester.step(5);
    stir();
    id_check("identification after reset");
    $display("Test identification done");
    // Preload twice; second capture sees enable latches high
    load_ir(6'h01);
    for (int k = 0; k < 2; k++) begin
      stir();
      pre = 10'(xs());
      if (k == 0) pre[7:6] = 2'b11;
      dr(10, rev(pre), rev(cap(1'b0)), "sample capture");
      lat = pre;
      pins("sample leaves pins to core");
    end
    $display("Test sample done");
    load_ir(6'h00);
    pins("external test drives latches");
    for (int k = 0; k < 2; k++) begin
      stir();
      pre = 10'(xs());
      dr(10, rev(pre), rev(cap(1'b1)), "external capture");
      lat = pre;
      pins("external update");
    end
    $display("Test external done");
    ops = '{6'h3E, 6'h3F, 6'h04 + 6'(xs() % 41), 6'h2E + 6'(xs() % 16), 6'h03};
    foreach (ops[k]) begin
      load_ir(ops[k]);
      stir();
      r = xs();
      dr(8, r, {24'h00_0000, r[6:0], 1'b0}, "one-bit bypass");
      pins("pins under bypass-path opcode");
    end
    $display("Test bypass done");
    repeat (5) i_tester.nav(1'b1, e);
    id_check("identification after mode reset");
    load_ir(6'h3F);
    i_tester.trst();
    id_check("identification after test reset");
    $display("Test reset done");
    finish_test();
  end
endmodule : boundary_scan_instruction_logic_tb
